// ==== design/tsp_timestamp_packing.sv ====
/*
 Receive timestamp handling, unit framing and word packing; transmit first-packet timestamp.
 Assumes stream and memory ports come from logic on CORE_CLK; memory write never stalls.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Keep mode stores 192-byte packets unchanged
// - Add mode prepends stamp to 188 bytes
// - Replace mode overwrites stamp in 192 bytes
// - Transmit reference from packet data when unpreset
// - Transmit reference from preset value when enabled
// - Non-stream sizes 200 to 256, step 8
// - No internal stamp at 256-byte size
// - Stream mode units are 192 bytes
// - Non-stream units are 256 bytes
// - Memory path is 64-bit words
// - Any format passes; stream mode checks sync
// - Little mode fills halves from top lane
// - First word: header high, stamp low
// - Big mode fills upward from bottom lane
// - Bits within a byte stay MSB first
module tsp_timestamp_packing (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic [tsp_pkg::REG_AW-1:0] REG_ADDR,
    input wire logic [tsp_pkg::REG_DW-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [tsp_pkg::REG_DW-1:0] REG_RDATA,
    input wire logic [tsp_pkg::BYTE_W-1:0] RX_DATA,
    input wire logic RX_VALID,
    input wire logic RX_SOP,
    output logic RX_READY,
    output logic [tsp_pkg::WORD_W-1:0] MEM_WDATA,
    output logic MEM_WVALID,
    input wire logic [tsp_pkg::WORD_W-1:0] MEM_RDATA,
    input wire logic MEM_RVALID,
    output logic MEM_RREADY,
    output logic [tsp_pkg::BYTE_W-1:0] TX_DATA,
    output logic TX_VALID,
    output logic TX_SOP,
    output logic [tsp_pkg::STAMP_W-1:0] TX_TS_REF,
    output logic TX_TS_REF_VALID
);
    import tsp_pkg::*;
    tsp_byte_if pk_if();
    tsp_byte_if up_if();

    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic preset_en_reg, preset_en_next, sync_err_reg, sync_err_next;
    logic [STAMP_W-1:0] preset_val_reg, preset_val_next, ts_cnt_reg, ts_cnt_next;
    logic [REG_DW-1:0] pkt_cnt_reg, pkt_cnt_next, rdata_reg, rdata_next;
    logic [1:0] mode;
    logic non_ts, be64, ts_en, rx_en, tx_en, replace, size_bad, lead_ts, lead_fill;
    logic [LEN_W-1:0] n_len, unit_len, body_len, sync_idx;

    tsp_rx_state_type st_reg, st_next;
    logic [LEN_W-1:0] ocnt_reg, ocnt_next, bcnt_reg, bcnt_next;
    logic [STAMP_W-1:0] ts_cap_reg, ts_cap_next;
    logic ready_reg, ready_next, take, emit, pkt_done, sync_hit;
    logic [BYTE_W-1:0] out_byte;

    logic [BYTE_W-1:0] tx_data_reg, tx_data_next;
    logic tx_valid_reg, tx_valid_next, tx_sop_reg, tx_sop_next;
    logic tx_first_reg, tx_first_next, ref_valid_reg, ref_valid_next;
    logic [LEN_W-1:0] tx_cnt_reg, tx_cnt_next;
    logic [STAMP_W-1:0] ref_reg, ref_next;

    assign mode = ctrl_reg[C_MODE_LSB +: C_MODE_W];
    assign non_ts = ctrl_reg[C_NONTS_BIT];
    assign be64 = ctrl_reg[C_BE64_BIT];
    assign ts_en = ctrl_reg[C_TSEN_BIT];
    assign rx_en = ctrl_reg[C_RXEN_BIT];
    assign tx_en = ctrl_reg[C_TXEN_BIT];
    // Size field is a step count, so only legal sizes can be chosen
    assign n_len = LEN_NT_MIN + {3'h0, ctrl_reg[C_SIZE_LSB +: C_SIZE_W], 3'h0};
    assign unit_len = non_ts ? LEN_NT_UNIT : LEN_TS_UNIT;
    // A stamp on a full 256-byte packet would not fit the unit, so it is dropped
    assign size_bad = non_ts && ts_en && (n_len == LEN_NT_MAX);
    assign replace = !non_ts && (mode == RX_TS_REPLACE);
    assign lead_ts = non_ts ? (ts_en && !size_bad) : ((mode == RX_TS_ADD) || replace);
    assign lead_fill = non_ts && !lead_ts && !be64 && (n_len != LEN_NT_MAX);
    assign body_len = non_ts ? n_len : (lead_ts ? LEN_TS_BODY : LEN_TS_UNIT);
    assign sync_idx = lead_ts ? '0 : LEN_STAMP;
    assign take = RX_VALID && ready_reg;

    always_comb
    begin
        st_next = st_reg;
        ocnt_next = ocnt_reg;
        bcnt_next = bcnt_reg;
        ts_cap_next = ts_cap_reg;
        emit = 1'b0;
        out_byte = '0;
        pkt_done = 1'b0;
        case (st_reg)
            ST_IDLE:
            begin
                if (rx_en && RX_VALID && RX_SOP)
                begin
                    ocnt_next = '0;
                    bcnt_next = '0;
                    ts_cap_next = ts_cnt_reg;
                    st_next = (lead_ts || lead_fill) ? ST_LEAD : ST_BODY;
                end
            end
            ST_LEAD:
            begin
                // Replace mode swallows the old stamp byte for byte
                emit = replace ? take : 1'b1;
                out_byte = lead_ts ? ts_cap_reg[STAMP_W-1 -: BYTE_W] : '0;
                if (emit)
                begin
                    ts_cap_next = {ts_cap_reg[STAMP_W-BYTE_W-1:0], 8'h00};
                    ocnt_next = ocnt_reg + LEN_ONE;
                    if (ocnt_reg == LEN_STAMP - LEN_ONE)
                        st_next = ST_BODY;
                end
            end
            ST_BODY:
            begin
                emit = take;
                out_byte = RX_DATA;
                if (take)
                begin
                    ocnt_next = ocnt_reg + LEN_ONE;
                    bcnt_next = bcnt_reg + LEN_ONE;
                    if (bcnt_reg == body_len - LEN_ONE)
                    begin
                        if (ocnt_reg == unit_len - LEN_ONE)
                        begin
                            st_next = ST_IDLE;
                            pkt_done = 1'b1;
                        end
                        else
                            st_next = ST_PAD;
                    end
                end
            end
            ST_PAD:
            begin
                emit = 1'b1;
                ocnt_next = ocnt_reg + LEN_ONE;
                if (ocnt_reg == unit_len - LEN_ONE)
                begin
                    st_next = ST_IDLE;
                    pkt_done = 1'b1;
                end
            end
            default:
                st_next = ST_IDLE;
        endcase
        ready_next = (st_next == ST_BODY) || ((st_next == ST_LEAD) && replace);
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            st_reg <= ST_IDLE;
            ocnt_reg <= '0;
            bcnt_reg <= '0;
            ts_cap_reg <= '0;
            ready_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            ocnt_reg <= ocnt_next;
            bcnt_reg <= bcnt_next;
            ts_cap_reg <= ts_cap_next;
            ready_reg <= ready_next;
        end
    end

    assign pk_if.data = out_byte;
    assign pk_if.valid = emit;
    assign pk_if.first = emit && (ocnt_reg == '0);
    assign pk_if.be64 = be64;
    tsp_packer u_packer (.clk(CORE_CLK), .rst(SYS_RST), .bus(pk_if));

    // Stream parsing: header must open with the sync byte
    assign sync_hit = take && (st_reg == ST_BODY) && !non_ts && (bcnt_reg == sync_idx)
        && (RX_DATA != SYNC_BYTE);

    always_comb
    begin
        ctrl_next = ctrl_reg;
        preset_en_next = preset_en_reg;
        preset_val_next = preset_val_reg;
        sync_err_next = sync_err_reg;
        ts_cnt_next = ts_cnt_reg + 32'h0000_0001;
        pkt_cnt_next = pkt_done ? pkt_cnt_reg + 32'h0000_0001 : pkt_cnt_reg;
        rdata_next = '0;
        if (REG_WR)
        begin
            case (REG_ADDR)
                CTRL_ADDR: ctrl_next = REG_WDATA[CTRL_W-1:0];
                PRESET_EN_ADDR: preset_en_next = REG_WDATA[P_EN_BIT];
                PRESET_VAL_ADDR: preset_val_next = REG_WDATA;
                STATUS_ADDR:
                begin
                    if (REG_WDATA[S_SYNC_BIT])
                        sync_err_next = 1'b0;
                end
                default: ;
            endcase
        end
        // A new error in the clearing cycle survives
        if (sync_hit)
            sync_err_next = 1'b1;
        if (REG_RD)
        begin
            case (REG_ADDR)
                CTRL_ADDR: rdata_next[CTRL_W-1:0] = ctrl_reg;
                PRESET_EN_ADDR: rdata_next[P_EN_BIT] = preset_en_reg;
                PRESET_VAL_ADDR: rdata_next = preset_val_reg;
                STATUS_ADDR:
                begin
                    rdata_next[S_SYNC_BIT] = sync_err_reg;
                    rdata_next[S_SIZE_BIT] = size_bad;
                    rdata_next[S_REF_BIT] = ref_valid_reg;
                end
                TSCNT_ADDR: rdata_next = ts_cnt_reg;
                PKTCNT_ADDR: rdata_next = pkt_cnt_reg;
                TXREF_ADDR: rdata_next = ref_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            ctrl_reg <= CTRL_RESET;
            preset_en_reg <= 1'b0;
            preset_val_reg <= '0;
            sync_err_reg <= 1'b0;
            ts_cnt_reg <= '0;
            pkt_cnt_reg <= '0;
            rdata_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            preset_en_reg <= preset_en_next;
            preset_val_reg <= preset_val_next;
            sync_err_reg <= sync_err_next;
            ts_cnt_reg <= ts_cnt_next;
            pkt_cnt_reg <= pkt_cnt_next;
            rdata_reg <= rdata_next;
        end
    end

    assign up_if.word = MEM_RDATA;
    assign up_if.word_valid = MEM_RVALID;
    assign up_if.be64 = be64;
    tsp_unpacker u_unpacker (.clk(CORE_CLK), .rst(SYS_RST), .bus(up_if));

    always_comb
    begin
        tx_data_next = up_if.data;
        tx_valid_next = up_if.valid;
        tx_sop_next = up_if.valid && (tx_cnt_reg == '0);
        tx_cnt_next = tx_cnt_reg;
        tx_first_next = tx_first_reg;
        ref_next = ref_reg;
        ref_valid_next = ref_valid_reg;
        if (!tx_en)
        begin
            tx_cnt_next = '0;
            tx_first_next = 1'b1;
            ref_valid_next = 1'b0;
        end
        else if (up_if.valid)
        begin
            tx_cnt_next = (tx_cnt_reg == unit_len - LEN_ONE) ? '0 : tx_cnt_reg + LEN_ONE;
            if (tx_first_reg && (tx_cnt_reg < LEN_STAMP))
            begin
                // Only the first packet after enable seeds the reference
                ref_next = preset_en_reg ? preset_val_reg : {ref_reg[STAMP_W-BYTE_W-1:0], up_if.data};
                if (tx_cnt_reg == LEN_STAMP - LEN_ONE)
                begin
                    ref_valid_next = 1'b1;
                    tx_first_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            tx_data_reg <= '0;
            tx_valid_reg <= 1'b0;
            tx_sop_reg <= 1'b0;
            tx_cnt_reg <= '0;
            tx_first_reg <= 1'b1;
            ref_reg <= '0;
            ref_valid_reg <= 1'b0;
        end
        else
        begin
            tx_data_reg <= tx_data_next;
            tx_valid_reg <= tx_valid_next;
            tx_sop_reg <= tx_sop_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_first_reg <= tx_first_next;
            ref_reg <= ref_next;
            ref_valid_reg <= ref_valid_next;
        end
    end

    assign REG_RDATA = rdata_reg;
    assign RX_READY = ready_reg;
    assign MEM_WDATA = pk_if.word;
    assign MEM_WVALID = pk_if.word_valid;
    assign MEM_RREADY = up_if.word_ready;
    assign TX_DATA = tx_data_reg;
    assign TX_VALID = tx_valid_reg;
    assign TX_SOP = tx_sop_reg;
    assign TX_TS_REF = ref_reg;
    assign TX_TS_REF_VALID = ref_valid_reg;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    sequence rx_start_s;
        (st_reg == ST_IDLE) && (st_next != ST_IDLE);
    endsequence

    keep_direct_a:
    assert property ((rx_start_s ##0 (!non_ts && mode == RX_TS_KEEP)) |=> st_reg == ST_BODY && ocnt_reg == '0)
        else $error("Keep mode did not go straight to body");
    add_lead_a:
    assert property ((rx_start_s ##0 (!non_ts && mode == RX_TS_ADD)) |=> (st_reg == ST_LEAD && emit)[*4]
        ##1 st_reg == ST_BODY)
        else $error("Add mode lead was not four stamp bytes");
    replace_lead_a:
    assert property ((rx_start_s ##0 replace) |=> st_reg == ST_LEAD && ready_reg)
        else $error("Replace mode does not consume the old stamp");
    tx_data_ref_a:
    assert property (($rose(ref_valid_reg) && !preset_en_reg) |-> ref_reg == {$past(tx_data_reg, 3),
        $past(tx_data_reg, 2), $past(tx_data_reg, 1), tx_data_reg})
        else $error("Transmit reference not taken from packet data");
    tx_preset_a:
    assert property (($rose(ref_valid_reg) && preset_en_reg) |-> ref_reg == preset_val_reg)
        else $error("Transmit reference not taken from preset");
    size_step_a:
    assert property (non_ts |-> n_len >= LEN_NT_MIN && n_len <= LEN_NT_MAX && n_len[2:0] == 3'h0)
        else $error("Packet size out of range or step");
    no_stamp_full_a:
    assert property ((st_reg == ST_LEAD && lead_ts && non_ts) |-> n_len != LEN_NT_MAX)
        else $error("Stamp inserted on a 256-byte packet");
    unit_end_a:
    assert property ((st_reg != ST_IDLE && st_next == ST_IDLE) |-> emit && ocnt_reg == unit_len - LEN_ONE)
        else $error("Unit ended at the wrong length");
    fill_zero_a:
    assert property ((st_reg == ST_LEAD && lead_fill) |-> out_byte == 8'h00 && !ready_reg)
        else $error("Filler lead is not zero");
endmodule
`default_nettype wire

// ==== pkg/tsp_pkg.sv ====
/*
 Constants, state type and byte-lane mapping shared by the timestamp packing block.
 Assumes one core clock; all offsets are byte addresses on a 32-bit register port with an 8-bit address.
*/
`default_nettype none
package tsp_pkg;
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 64;
    localparam int STAMP_W = 32;
    localparam int LEN_W = 9;
    localparam int IDX_W = 3;
    localparam logic [REG_AW-1:0] CTRL_ADDR = 8'h00;
    localparam logic [REG_AW-1:0] PRESET_EN_ADDR = 8'h04;
    localparam logic [REG_AW-1:0] PRESET_VAL_ADDR = 8'h08;
    localparam logic [REG_AW-1:0] STATUS_ADDR = 8'h0C;
    localparam logic [REG_AW-1:0] TSCNT_ADDR = 8'h10;
    localparam logic [REG_AW-1:0] PKTCNT_ADDR = 8'h14;
    localparam logic [REG_AW-1:0] TXREF_ADDR = 8'h18;
    localparam int CTRL_W = 10;
    localparam int C_MODE_LSB = 0;
    localparam int C_MODE_W = 2;
    localparam int C_NONTS_BIT = 2;
    localparam int C_BE64_BIT = 3;
    localparam int C_TSEN_BIT = 4;
    localparam int C_SIZE_LSB = 5;
    localparam int C_SIZE_W = 3;
    localparam int C_RXEN_BIT = 8;
    localparam int C_TXEN_BIT = 9;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
    localparam int S_SYNC_BIT = 0;
    localparam int S_SIZE_BIT = 1;
    localparam int S_REF_BIT = 2;
    localparam int P_EN_BIT = 0;
    localparam logic [1:0] RX_TS_KEEP = 2'h0;
    localparam logic [1:0] RX_TS_ADD = 2'h1;
    localparam logic [1:0] RX_TS_REPLACE = 2'h2;
    localparam logic [LEN_W-1:0] LEN_ONE = 9'h001;
    localparam logic [LEN_W-1:0] LEN_STAMP = 9'h004;
    localparam logic [LEN_W-1:0] LEN_TS_UNIT = 9'h0C0;
    localparam logic [LEN_W-1:0] LEN_TS_BODY = 9'h0BC;
    localparam logic [LEN_W-1:0] LEN_NT_UNIT = 9'h100;
    localparam logic [LEN_W-1:0] LEN_NT_MIN = 9'h0C8;
    localparam logic [LEN_W-1:0] LEN_NT_MAX = 9'h100;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
    localparam logic [BYTE_W-1:0] SYNC_BYTE = 8'h47;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_BODY = 2'b11,
        ST_PAD = 2'b10
    } tsp_rx_state_type;
    // Bit offset of the k-th byte of a word; bytes stay whole, MSB first
    function automatic logic [5:0] tsp_lane(input logic [IDX_W-1:0] k, input logic be64);
        tsp_lane = be64 ? {k, 3'h0} : {k[2], ~k[1:0], 3'h0};
    endfunction
endpackage
`default_nettype wire

// ==== pkg/tsp_byte_if.sv ====
/*
 Byte stream to and from 64-bit memory words, between the top and its packer and unpacker.
 Assumes both ends run on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface tsp_byte_if;
    logic [7:0] data;
    logic valid;
    logic first;
    logic be64;
    logic [63:0] word;
    logic word_valid;
    logic word_ready;
    modport packer_side (input data, valid, first, be64, output word, word_valid);
    modport pk_user (output data, valid, first, be64, input word, word_valid);
    modport unpacker_side (input word, word_valid, be64, output data, valid, word_ready);
    modport up_user (output word, word_valid, be64, input data, valid, word_ready);
endinterface
`default_nettype wire

// ==== design/tsp_packer.sv ====
/*
 Packs a byte stream into 64-bit memory words in either storage layout.
 Assumes every unit starts with first high and is a multiple of eight bytes.
*/
`timescale 1ns/1ps
`default_nettype none
module tsp_packer (
    input wire logic clk,
    input wire logic rst,
    tsp_byte_if.packer_side bus
);
    import tsp_pkg::*;
    logic [WORD_W-1:0] acc_reg, acc_next, out_reg, out_next;
    logic [IDX_W-1:0] idx_reg, idx_next;
    logic ov_reg, ov_next;

    always_comb
    begin
        logic [WORD_W-1:0] tmp;
        logic [IDX_W-1:0] pos;
        tmp = bus.first ? '0 : acc_reg;
        pos = bus.first ? '0 : idx_reg;
        acc_next = acc_reg;
        idx_next = idx_reg;
        out_next = out_reg;
        ov_next = 1'b0;
        if (bus.valid)
        begin
            tmp[tsp_lane(pos, bus.be64) +: BYTE_W] = bus.data;
            if (pos == IDX_LAST)
            begin
                out_next = tmp;
                ov_next = 1'b1;
                acc_next = '0;
                idx_next = '0;
            end
            else
            begin
                acc_next = tmp;
                idx_next = pos + 3'h1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_reg <= '0;
            out_reg <= '0;
            idx_reg <= '0;
            ov_reg <= 1'b0;
        end
        else
        begin
            acc_reg <= acc_next;
            out_reg <= out_next;
            idx_reg <= idx_next;
            ov_reg <= ov_next;
        end
    end

    assign bus.word = out_reg;
    assign bus.word_valid = ov_reg;

    word_cause_a:
    assert property (@(posedge clk) disable iff (rst) bus.word_valid |-> $past(bus.valid))
        else $error("Word emitted without a byte before it");
endmodule
`default_nettype wire

// ==== design/tsp_unpacker.sv ====
/*
 Splits 64-bit memory words back into bytes in stream order, one byte a cycle.
 Assumes the source offers a word only while word_ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
module tsp_unpacker (
    input wire logic clk,
    input wire logic rst,
    tsp_byte_if.unpacker_side bus
);
    import tsp_pkg::*;
    logic [WORD_W-1:0] word_reg, word_next;
    logic [IDX_W-1:0] idx_reg, idx_next;
    logic busy_reg, busy_next, ready_reg, ready_next, valid_reg, valid_next;
    logic [BYTE_W-1:0] data_reg, data_next;

    always_comb
    begin
        word_next = word_reg;
        idx_next = idx_reg;
        busy_next = busy_reg;
        data_next = data_reg;
        valid_next = 1'b0;
        if (busy_reg)
        begin
            data_next = word_reg[tsp_lane(idx_reg, bus.be64) +: BYTE_W];
            valid_next = 1'b1;
            idx_next = idx_reg + 3'h1;
            if (idx_reg == IDX_LAST)
                busy_next = 1'b0;
        end
        else if (bus.word_valid)
        begin
            word_next = bus.word;
            busy_next = 1'b1;
            idx_next = '0;
        end
        ready_next = !busy_next;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            word_reg <= '0;
            idx_reg <= '0;
            busy_reg <= 1'b0;
            ready_reg <= 1'b1;
            valid_reg <= 1'b0;
            data_reg <= '0;
        end
        else
        begin
            word_reg <= word_next;
            idx_reg <= idx_next;
            busy_reg <= busy_next;
            ready_reg <= ready_next;
            valid_reg <= valid_next;
            data_reg <= data_next;
        end
    end

    assign bus.data = data_reg;
    assign bus.valid = valid_reg;
    assign bus.word_ready = ready_reg;
endmodule
`default_nettype wire

// ==== sim/tsp_mem_model.sv ====
/*
 Memory-side model: keeps written words and replays them as read words.
 Assumes the bench pulses start; hold stalls new offers.
*/
`timescale 1ns/1ps
`default_nettype none
module tsp_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [63:0] wdata,
    input wire logic wvalid,
    input wire logic start,
    input wire logic hold,
    input wire logic [5:0] count,
    input wire logic rready,
    output logic [63:0] rdata = 64'h0,
    output logic rvalid = 1'b0
);
    logic [63:0] mem [0:31];
    logic [4:0] wptr;
    logic [5:0] rptr;
    always @(posedge clk)
    begin
        if (wvalid)
            mem[wptr] <= wdata;
        wptr <= (rst || start) ? 5'h0 : wptr + 5'(wvalid);
        if (rst || start)
            rptr <= rst ? 6'h3F : 6'h0;
        if (rst)
            rvalid <= 1'b0;
        else if (rvalid && rready)
        begin
            rptr <= rptr + 6'h1;
            rvalid <= 1'b0;
            rdata <= ~rdata; // Released bus must not repeat the word
        end
        else if (!rvalid && !hold && !start && rptr < count)
        begin
            rvalid <= 1'b1;
            rdata <= mem[rptr[4:0]];
        end
    end
endmodule
`default_nettype wire

// ==== sim/tsp_timestamp_packing_test.sv ====
/*
 Self-checking bench for the timestamp packing block.
 Assumes tsp_mem_model on the memory side and one core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tsp_timestamp_packing_test;
    import tsp_pkg::*;
    logic CORE_CLK = 1'b0, SYS_RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, RX_VALID = 1'b0, RX_SOP = 1'b0;
    logic start = 1'b0, hold = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, RX_DATA = 8'h00, TX_DATA;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, TX_TS_REF;
    logic [63:0] MEM_WDATA, MEM_RDATA;
    logic RX_READY, MEM_WVALID, MEM_RVALID, MEM_RREADY, TX_VALID, TX_SOP, TX_TS_REF_VALID;
    logic [7:0] bytes [0:255];
    logic [63:0] wq [$];
    logic [63:0] mq [$];
    logic [8:0] tq [$];
    int seed = 32'hC6B4;
    int fails = 0;
    int checked = 0;
    tsp_timestamp_packing i_dut (.CORE_CLK, .SYS_RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
        .RX_DATA, .RX_VALID, .RX_SOP, .RX_READY, .MEM_WDATA, .MEM_WVALID, .MEM_RDATA, .MEM_RVALID,
        .MEM_RREADY, .TX_DATA, .TX_VALID, .TX_SOP, .TX_TS_REF, .TX_TS_REF_VALID);
    tsp_mem_model i_mem (.clk(CORE_CLK), .rst(SYS_RST), .wdata(MEM_WDATA), .wvalid(MEM_WVALID), .start(start),
        .hold(hold), .count(6'h18), .rready(MEM_RREADY), .rdata(MEM_RDATA), .rvalid(MEM_RVALID));
    always #25 CORE_CLK = ~CORE_CLK;
    task automatic tally_and_finish;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic give_up;
        fails++;
        tally_and_finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input logic [63:0] mask);
        checked++;
        if (((got ^ exp) & mask) !== 64'h0)
        begin
            fails++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
        // Idle edge so a following write never re-raises the strobe in this step
        @(posedge CORE_CLK);
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1;
        check(64'(REG_RDATA), 64'(exp), 64'(mask));
        @(posedge CORE_CLK);
    endtask
    task automatic wait_empty;
        int t;
        for (t = 0; wq.size() + tq.size() != 0; t++)
        begin
            if (t > 3000)
                give_up;
            @(posedge CORE_CLK);
        end
        repeat (4) @(posedge CORE_CLK);
    endtask
    // Stamp bytes are masked: their value depends on when the packet arrived
    task automatic run_rx(input logic [9:0] c, input int lead, input int n, input int unit, input int mk);
        int i, j, k, p, t;
        logic [63:0] w, m;
        reg_wr(CTRL_ADDR, {22'h0, c});
        for (i = 0; i < 256; i++)
            bytes[i] = (i == 0 || i == 4) ? SYNC_BYTE : 8'($random(seed));
        for (j = 0; j < unit; j++)
        begin
            k = j % 8;
            p = c[3] ? k * 8 : (k / 4) * 32 + (3 - k % 4) * 8;
            w[p +: 8] = (j < lead || j >= lead + n) ? 8'h00 : bytes[j - lead];
            m[p +: 8] = (j < mk) ? 8'h00 : 8'hFF;
            if (k == 7)
            begin
                wq.push_back(w);
                mq.push_back(m);
            end
        end
        for (i = 0; i < n; i++)
        begin
            RX_DATA <= bytes[i];
            RX_VALID <= 1'b1;
            RX_SOP <= (i == 0);
            @(posedge CORE_CLK);
            for (t = 0; RX_READY !== 1'b1; t++)
            begin
                if (t > 50)
                    give_up;
                @(posedge CORE_CLK);
            end
        end
        RX_VALID <= 1'b0;
        RX_SOP <= 1'b0;
        wait_empty;
    endtask
    task automatic run_tx(input logic pre, input logic [31:0] pv);
        int i;
        reg_wr(CTRL_ADDR, 32'h0);
        reg_wr(PRESET_EN_ADDR, {31'h0, pre});
        reg_wr(PRESET_VAL_ADDR, pv);
        reg_wr(CTRL_ADDR, 32'h200);
        for (i = 0; i < 192; i++)
            tq.push_back({i == 0, bytes[i]});
        start <= 1'b1;
        @(posedge CORE_CLK);
        start <= 1'b0;
        wait_empty;
        check(64'(TX_TS_REF_VALID), 64'h1, 64'h1);
        check(64'(TX_TS_REF), pre ? 64'(pv) : 64'({bytes[0], bytes[1], bytes[2], bytes[3]}), 64'hFFFFFFFF);
    endtask
    always @(posedge CORE_CLK)
    begin
        hold <= 1'($random(seed));
        if (MEM_WVALID === 1'b1)
            check(MEM_WDATA, wq.size() > 0 ? wq.pop_front() : ~MEM_WDATA, mq.size() > 0 ? mq.pop_front() : 64'h1);
        if (TX_VALID === 1'b1)
            check(64'({TX_SOP, TX_DATA}), tq.size() > 0 ? 64'(tq.pop_front()) : ~64'({TX_SOP, TX_DATA}), 64'h1FF);
    end
    initial
    begin
        repeat (3) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        reg_rd(CTRL_ADDR, 32'h0, 32'hFFFFFFFF);
        reg_wr(8'hFC, 32'hFFFFFFFF);
        reg_rd(8'hFC, 32'h0, 32'hFFFFFFFF);
        run_rx(10'h100, 0, 192, 192, 0);
        run_tx(1'b1, 32'h5A3C96E1);
        run_tx(1'b0, 32'h0);
        run_rx(10'h101, 4, 188, 192, 4);
        run_rx(10'h102, 0, 192, 192, 4);
        run_rx(10'h108, 0, 192, 192, 0);
        run_rx(10'h104, 4, 200, 256, 0);
        run_rx(10'h1D4, 4, 248, 256, 4);
        run_rx(10'h1E4, 0, 256, 256, 0);
        reg_wr(CTRL_ADDR, 32'h0F4);
        reg_rd(STATUS_ADDR, 32'h2, 32'h7);
        tally_and_finish;
    end
endmodule
`default_nettype wire
